// ### slc_device.sv
// Command interpreter of the serial-link interface processor: command and
// data registers on the register port, channel control on the user side.
// Assumes the channel logic answers each start or transfer with ok or fail.
//
// How it works
// - Command word in low 16 bits
// - Bit 15 marks a parameter write
// - Bit 14 resets processor, opens program store
// - Bit 13 requests local parameter access
// - Bit 12 selects process data transfer
// - Bit 11 start/stop, type in 10:8
// - Type 000 stops masked channels
// - Type 001 starts masked channels normally
// - Type 111 starts masked channels in setup
// - Low byte mask selects channels
// - Writing command launches it
// - Completion clears command register to zero
// - Reads during execution return last command
// - Host writes command while non-zero only for stop-all or ignored words
// - Stop-all accepted anytime, resets interface
// - Command writes with bit 31 set are ignored
// - 8-bit data register in low bits
// - Parameter read: command, poll, read data
// - Parameter write: poll, data, then command
// - Stop-all resets channels, idles all links
// - Transfer completes when all done or timed out
// - Data register gets per-channel failure mask
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`default_nettype none

module slc_device
  import slc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = slc_pkg::XFER_TIMEOUT_CYC
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  slc_port_if.dev                        port,
  output logic      [slc_pkg::NCH-1:0]   chan_start,
  output logic                           chan_setup,
  output logic      [slc_pkg::NCH-1:0]   chan_stop,
  output logic      [slc_pkg::NCH-1:0]   chan_xfer,
  output logic                           chan_reset_all,
  output logic                           proc_reset,
  output logic                           prog_open,
  input  wire logic [slc_pkg::NCH-1:0]   chan_ok,
  input  wire logic [slc_pkg::NCH-1:0]   chan_fail
);
  import slc_pkg::*;

  slc_state_t             state_r;
  logic [CMD_W-1:0]       cmd_r;
  logic [DATA_W-1:0]      data_r;
  logic [NCH-1:0]         pend_r;
  logic [NCH-1:0]         fail_r;
  logic [31:0]            tmr_r;
  logic                   wait_kind_r;
  logic [31:0]            rdata_r;
  logic                   rack_r;
  logic [DATA_W-1:0]      param_mem [PARAM_DEPTH];

  logic                   cmd_wr;
  logic                   cmd_take;
  logic                   is_reset;
  logic                   is_xfer;
  logic                   is_ss;
  logic                   is_req;
  logic [2:0]             ss_type;
  logic [NCH-1:0]         mask;
  logic                   tmo;
  logic [NCH-1:0]         fail_nxt;
  logic [NCH-1:0]         pend_nxt;

  assign cmd_wr   = port.wr && (port.sel == SEL_CMD) && !port.wdata[BIT_IGNORE];
  // write launches; busy writes dropped; stop-all always taken
  assign cmd_take = ce && cmd_wr &&
                    ((state_r == ST_IDLE) || (port.wdata[CMD_W-1:0] == CMD_STOP_ALL));

  assign is_reset = cmd_r[BIT_RESET];
  assign is_xfer  = cmd_r[BIT_XFER];
  assign is_ss    = cmd_r[BIT_STARTSTP];
  assign is_req   = cmd_r[BIT_REQUEST];
  assign ss_type  = cmd_r[TYPE_MSB:TYPE_LSB];
  assign mask     = cmd_r[NCH-1:0];

  assign tmo      = (tmr_r >= TIMEOUT_CYC - 1);
  assign pend_nxt = pend_r & ~(chan_ok | chan_fail);
  assign fail_nxt = fail_r | (chan_fail & pend_r) | (tmo ? pend_nxt : {NCH{1'b0}});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      if (cmd_take) begin
        state_r <= ST_EXEC;
      end else begin
        unique case (state_r)
          ST_IDLE: state_r <= ST_IDLE;
          ST_EXEC: begin
            // wait on started or transferring channels
            if (!is_reset && (is_xfer || (is_ss && (ss_type == TYPE_NORMAL ||
                ss_type == TYPE_SETUP))) && (mask != '0)) begin
              state_r <= ST_WAIT;
            end else begin
              state_r <= ST_DONE;
            end
          end
          ST_WAIT: begin
            if ((pend_nxt == '0) || tmo) begin
              state_r <= ST_DONE;
            end
          end
          ST_DONE: state_r <= ST_IDLE;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= CMD_IDLE;
    end else if (ce) begin
      if (cmd_take) begin
        cmd_r <= port.wdata[CMD_W-1:0];
      end else if (state_r == ST_DONE) begin
        cmd_r <= CMD_IDLE;
      end
    end
  end

  // Channel pending, failure and timer tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r      <= '0;
      fail_r      <= '0;
      tmr_r       <= '0;
      wait_kind_r <= 1'b0;
    end else if (ce) begin
      if (state_r == ST_EXEC && !cmd_take) begin
        pend_r      <= mask;
        fail_r      <= '0;
        tmr_r       <= '0;
        wait_kind_r <= !is_reset && (is_xfer || (is_ss && (ss_type == TYPE_NORMAL ||
                       ss_type == TYPE_SETUP)));
      end else if (state_r == ST_WAIT) begin
        pend_r <= pend_nxt;
        fail_r <= fail_nxt;
        tmr_r  <= tmr_r + 32'h1;
      end else if (cmd_take) begin
        // Stop-all abandons whatever was outstanding
        pend_r <= '0;
      end
    end
  end

  // Channel control pulses, one cycle wide; chan_setup is a level held until the next start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_start     <= '0;
      chan_setup     <= 1'b0;
      chan_stop      <= '0;
      chan_xfer      <= '0;
      chan_reset_all <= 1'b0;
      proc_reset     <= 1'b0;
    end else if (ce) begin
      chan_start     <= '0;
      chan_stop      <= '0;
      chan_xfer      <= '0;
      chan_reset_all <= 1'b0;
      proc_reset     <= 1'b0;
      if (state_r == ST_EXEC && !cmd_take) begin
        if (is_reset) begin
          proc_reset <= 1'b1;
        end else if (is_xfer) begin
          chan_xfer <= mask;
        end else if (is_ss) begin
          unique case (ss_type)
            TYPE_STOP: begin
              if (mask == '0) begin
                // stop-all resets and idles every link
                chan_reset_all <= 1'b1;
                chan_stop      <= {NCH{1'b1}};
              end else begin
                chan_stop <= mask;
              end
            end
            TYPE_NORMAL: begin
              chan_start <= mask;
              chan_setup <= 1'b0;
            end
            TYPE_SETUP: begin
              chan_start <= mask;
              chan_setup <= 1'b1;
            end
            default: chan_start <= '0;
          endcase
        end
      end
    end
  end

  // Program store stays open until the next command is accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_open <= 1'b0;
    end else if (ce) begin
      if (cmd_take) begin
        prog_open <= 1'b0;
      end else if (state_r == ST_EXEC && is_reset) begin
        prog_open <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_r <= DATA_RESET;
    end else if (ce) begin
      if (state_r == ST_DONE && wait_kind_r) begin
        // failure mask after start or transfer
        data_r <= fail_r;
      end else if (state_r == ST_EXEC && !cmd_take && !is_reset && !is_xfer &&
                   !is_ss && is_req && !cmd_r[BIT_WRITE]) begin
        data_r <= param_mem[cmd_r[7:0]];
      end else if (port.wr && port.sel == SEL_DATA) begin
        data_r <= port.wdata[DATA_W-1:0];
      end
    end
  end

  // local parameter write; store is not reset, contents are software's
  always_ff @(posedge aclk) begin
    if (ce && state_r == ST_EXEC && !cmd_take && !is_reset && !is_xfer && !is_ss &&
        is_req && cmd_r[BIT_WRITE]) begin
      param_mem[cmd_r[7:0]] <= data_r;
    end
  end

  // reads show the stored command until completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= '0;
      rack_r  <= 1'b0;
    end else if (ce) begin
      rack_r <= port.rd;
      if (port.rd) begin
        rdata_r <= (port.sel == SEL_DATA) ? {24'h000000, data_r} : {16'h0000, cmd_r};
      end
    end
  end

  assign port.rdata = rdata_r;
  assign port.rack  = rack_r;

endmodule

`default_nettype wire

// ### slc_host.sv
// Controller end: software reaches its registers over AXI4-Lite and it
// drives the interpreter's register port, mirroring command and data by polling.
// Assumes one write and one read at most in flight on the AXI side.
`default_nettype none

module slc_host
  import slc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  slc_port_if.hst          port
);
  import slc_pkg::*;

  logic [7:0]        aw_addr_r;
  logic [31:0]       w_data_r;
  logic              wq_v_r;
  logic              wq_sel_r;
  logic [31:0]       wq_data_r;
  logic              wr_r;
  logic              rd_r;
  logic              sel_r;
  logic [31:0]       pwdata_r;
  logic              rd_out_r;
  logic              poll_sel_r;
  logic [CMD_W-1:0]  cmd_m_r;
  logic [DATA_W-1:0] data_m_r;
  logic              refused_r;
  logic              do_wr;
  logic              refuse;
  logic              clr_ref;

  // Both halves of the write held, queue slot free
  assign do_wr   = ce && !awready && !wready && !bvalid && !wq_v_r;
  // hold back commands while busy, except stop-all and ignored words
  assign refuse  = do_wr && aw_addr_r == HR_CMD && cmd_m_r != CMD_IDLE &&
                   w_data_r[CMD_W-1:0] != CMD_STOP_ALL && !w_data_r[BIT_IGNORE];
  assign clr_ref = do_wr && aw_addr_r == HR_STAT && wstrb[0] && w_data_r[STAT_REFUSED];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r  <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_data_r <= wdata;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp  <= (aw_addr_r == HR_CMD || aw_addr_r == HR_DATA || aw_addr_r == HR_STAT) ?
                  RESP_OKAY : RESP_DECERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Pending link write and sticky refusal; a refusal beats its own clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wq_v_r    <= 1'b0;
      wq_sel_r  <= SEL_CMD;
      wq_data_r <= '0;
      refused_r <= 1'b0;
    end else if (ce) begin
      refused_r <= refuse | (refused_r & ~clr_ref);
      if (do_wr && !refuse && (aw_addr_r == HR_CMD || aw_addr_r == HR_DATA)) begin
        wq_v_r    <= 1'b1;
        wq_sel_r  <= (aw_addr_r == HR_DATA) ? SEL_DATA : SEL_CMD;
        wq_data_r <= w_data_r;
      end else if (wq_v_r && !rd_out_r) begin
        wq_v_r <= 1'b0;
      end
    end
  end

  // Link side: writes go first, otherwise poll command and data in turn
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_r       <= 1'b0;
      rd_r       <= 1'b0;
      sel_r      <= SEL_CMD;
      pwdata_r   <= '0;
      rd_out_r   <= 1'b0;
      poll_sel_r <= SEL_CMD;
      cmd_m_r    <= CMD_IDLE;
      data_m_r   <= DATA_RESET;
    end else if (ce) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      if (rd_out_r) begin
        if (port.rack) begin
          rd_out_r <= 1'b0;
          if (poll_sel_r == SEL_DATA) begin
            cmd_m_r <= port.rdata[CMD_W-1:0];
          end else begin
            data_m_r <= port.rdata[DATA_W-1:0];
          end
        end
      end else if (wq_v_r) begin
        wr_r     <= 1'b1;
        sel_r    <= wq_sel_r;
        pwdata_r <= wq_data_r;
        // Mirror follows at once so software never sees a stale zero
        if (wq_sel_r == SEL_DATA) begin
          data_m_r <= wq_data_r[DATA_W-1:0];
        end else if (!wq_data_r[BIT_IGNORE]) begin
          cmd_m_r <= wq_data_r[CMD_W-1:0];
        end
      end else begin
        rd_r       <= 1'b1;
        sel_r      <= poll_sel_r;
        rd_out_r   <= 1'b1;
        poll_sel_r <= ~poll_sel_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= RESP_OKAY;
        unique case (araddr)
          HR_CMD:  rdata <= {16'h0000, cmd_m_r};
          HR_DATA: rdata <= {24'h000000, data_m_r};
          HR_STAT: rdata <= {30'h00000000, refused_r, cmd_m_r != CMD_IDLE};
          default: begin
            rdata <= '0;
            rresp <= RESP_DECERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  assign port.wr    = wr_r;
  assign port.rd    = rd_r;
  assign port.sel   = sel_r;
  assign port.wdata = pwdata_r;

endmodule

`default_nettype wire

// ### slc_link_sva.sv
// Checker for the register port between controller and interpreter.
// Assumes both ends run on aclk with the synchronous active-low aresetn.
`default_nettype none

module slc_link_sva
  import slc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        sel,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        rack
);
  timeunit 1ns;
  timeprecision 1ps;
  import slc_pkg::*;

  logic       rsel_r;
  logic [7:0] age_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk) begin
    if (rd) begin
      rsel_r <= sel;
    end
  end

  // Edges since a stop-all went over the link; FF means none pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age_r <= 8'hFF;
    end else if (wr && sel == SEL_CMD && !wdata[BIT_IGNORE]) begin
      age_r <= (wdata[15:0] == CMD_STOP_ALL) ? 8'h00 : 8'hFF;
    end else if (age_r < 8'hC8) begin
      age_r <= age_r + 8'h01;
    end
  end

  chk_rd_answer_next:
    assert property (rd |=> rack) else $error("read strobe not answered next cycle");
  chk_rack_has_cause:
    assert property (rack |-> $past(rd)) else $error("read answer without a read");
  chk_one_strobe:
    assert property (!(wr && rd)) else $error("write and read strobe together");
  chk_wr_pulse_once:
    assert property (wr |=> !wr) else $error("write strobe longer than one cycle");
  chk_cmd_upper_zero:
    assert property (rack && rsel_r == SEL_CMD |-> rdata[31:16] == 16'h0000)
      else $error("command read has upper bits set");
  chk_data_upper_zero:
    assert property (rack && rsel_r == SEL_DATA |-> rdata[31:8] == 24'h000000)
      else $error("data read has upper bits set");
  chk_rdata_held:
    assert property (!rack |-> $stable(rdata)) else $error("read word changed without answer");
  chk_stopall_clears:
    assert property (rack && rsel_r == SEL_CMD && age_r >= 8'h06 && age_r <= 8'hC8
      |-> rdata[15:0] == CMD_IDLE) else $error("command not cleared after stop-all");

  cov_stop_all: cover property (wr && sel == SEL_CMD && wdata[15:0] == CMD_STOP_ALL);
  cov_cmd_read: cover property (rack && rsel_r == SEL_CMD && rdata[15:0] != CMD_IDLE);
  cov_data_read: cover property (rack && rsel_r == SEL_DATA && rdata[7:0] != 8'h00);
endmodule

`default_nettype wire

// ### slc_pkg.sv
// Shared constants for the serial-link command port: command word layout,
// port selects, start/stop types, timing and the controller's register map.
// Assumes a single 125 MHz clock shared by both ends.
`default_nettype none

package slc_pkg;

  // Command word fields
  localparam int          CMD_W        = 16;
  localparam int          BIT_WRITE    = 15;
  localparam int          BIT_RESET    = 14;
  localparam int          BIT_REQUEST  = 13;
  localparam int          BIT_XFER     = 12;
  localparam int          BIT_STARTSTP = 11;
  localparam int          TYPE_MSB     = 10;
  localparam int          TYPE_LSB     = 8;
  localparam int          BIT_IGNORE   = 31;
  localparam int          NCH          = 8;
  localparam int          DATA_W       = 8;

  localparam logic [2:0]  TYPE_STOP    = 3'h0;
  localparam logic [2:0]  TYPE_NORMAL  = 3'h1;
  localparam logic [2:0]  TYPE_SETUP   = 3'h7;
  localparam logic [15:0] CMD_STOP_ALL = 16'h0800;
  localparam logic [15:0] CMD_IDLE     = 16'h0000;
  localparam logic [7:0]  DATA_RESET   = 8'h00;

  // Register port selects
  localparam logic        SEL_CMD      = 1'b0;
  localparam logic        SEL_DATA     = 1'b1;

  // Local parameter store depth, addressed by the low command byte
  localparam int          PARAM_DEPTH  = 256;

  // Transfer timeout: longest wait, rounded down to whole cycles
  localparam int          CLK_PERIOD_NS   = 8;
  localparam int          XFER_TIMEOUT_NS = 100000;
  localparam int          XFER_TIMEOUT_CYC = XFER_TIMEOUT_NS / CLK_PERIOD_NS;

  // Controller registers seen by software over AXI4-Lite
  localparam logic [7:0]  HR_CMD       = 8'h00;
  localparam logic [7:0]  HR_DATA      = 8'h04;
  localparam logic [7:0]  HR_STAT      = 8'h08;
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_REFUSED = 1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } slc_state_t;

endpackage

`default_nettype wire

// ### slc_port_if.sv
// Register port between the controller and the command interpreter.
// Both ends sit on the same clock; a read answers one cycle later.
`default_nettype none

interface slc_port_if;
  logic        wr;
  logic        rd;
  logic        sel;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rack;

  modport dev (input wr, input rd, input sel, input wdata, output rdata, output rack);
  modport hst (output wr, output rd, output sel, output wdata, input rdata, input rack);
endinterface

`default_nettype wire

// ### testbench.sv
// Bench: software side over AXI4-Lite, channel logic answered by a small responder.
// Assumes slc_pkg, slc_port_if, slc_device, slc_host and slc_link_sva are compiled first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import slc_pkg::*;

  localparam int TMO = 60;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  chan_start, chan_stop, chan_xfer;
  logic        chan_setup, chan_reset_all, proc_reset, prog_open;
  logic [7:0]  chan_ok = '0, chan_fail = '0, fail_mask = '0, mute_mask = '0, rsp_pend = '0;
  int          rsp_cnt = 0;
  logic [7:0]  seen_start = '0, seen_stop = '0, seen_xfer = '0;
  logic        seen_setup = 1'b0, seen_rst = 1'b0, seen_proc = 1'b0, clr = 1'b0;
  int          err_count = 0, n_checks = 0;
  logic [1:0]  r;
  logic [31:0] d;

  slc_port_if lnk();
  slc_device #(.TIMEOUT_CYC(TMO)) slc_device_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .port(lnk.dev), .chan_start(chan_start), .chan_setup(chan_setup), .chan_stop(chan_stop),
    .chan_xfer(chan_xfer), .chan_reset_all(chan_reset_all), .proc_reset(proc_reset),
    .prog_open(prog_open), .chan_ok(chan_ok), .chan_fail(chan_fail));
  slc_host slc_host_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .port(lnk.hst));
  slc_link_sva slc_link_sva_i (.aclk(aclk), .aresetn(aresetn), .wr(lnk.wr), .rd(lnk.rd),
    .sel(lnk.sel), .wdata(lnk.wdata), .rdata(lnk.rdata), .rack(lnk.rack));

  initial begin
    forever #4 aclk = ~aclk;
  end

  // Channel logic: muted channels never answer, so only the timeout or a stop-all ends them
  always @(posedge aclk) begin
    chan_ok <= '0;
    chan_fail <= '0;
    if (rsp_cnt != 0) begin
      rsp_cnt <= rsp_cnt - 1;
      if (rsp_cnt == 1) begin
        chan_ok <= rsp_pend & ~fail_mask & ~mute_mask;
        chan_fail <= rsp_pend & fail_mask & ~mute_mask;
      end
    end else if ((chan_start | chan_xfer) != 8'h00) begin
      rsp_pend <= chan_start | chan_xfer;
      rsp_cnt <= 3;
    end
  end

  always @(posedge aclk) begin
    if (clr) begin
      {seen_start, seen_stop, seen_xfer, seen_setup, seen_rst, seen_proc} <= '0;
    end else begin
      seen_start <= seen_start | chan_start;
      seen_stop <= seen_stop | chan_stop;
      seen_xfer <= seen_xfer | chan_xfer;
      seen_rst <= seen_rst | chan_reset_all;
      seen_proc <= seen_proc | proc_reset;
      if (chan_start != 8'h00) seen_setup <= chan_setup;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    err_count++;
    $display("[ERR] %0t wait ran out: %s", $time, what);
    summarize();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    int i;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 100) hang("write response");
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 100) hang("read response");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_rd(a);
    check(d, exp, "read word");
    check({30'h0, r}, {30'h0, er}, "read response");
  endtask

  // The host forwards a command a couple of cycles after its response
  task automatic cmd(input logic [31:0] v, input logic [7:0] fm, input logic [7:0] mm);
    clr <= 1'b1;
    fail_mask <= fm;
    mute_mask <= mm;
    @(posedge aclk);
    clr <= 1'b0;
    axi_wr(HR_CMD, v);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "command write response");
    repeat (4) @(posedge aclk);
  endtask

  // The data mirror is polled after the command mirror, so let it catch up
  task automatic wait_idle();
    int i;
    for (i = 0; i < 100; i++) begin
      axi_rd(HR_CMD);
      if (d === 32'h0) break;
    end
    if (i == 100) hang("command completion");
    repeat (12) @(posedge aclk);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(HR_CMD, 32'h0, RESP_OKAY);
    rd_chk(HR_DATA, 32'h0, RESP_OKAY);
    rd_chk(8'h0C, 32'h0, RESP_DECERR);
    cmd(32'h0901, 8'h00, 8'h00);
    wait_idle();
    check({23'h0, seen_setup, seen_start}, 32'h001, "normal start");
    rd_chk(HR_DATA, 32'h00, RESP_OKAY);
    cmd(32'h0F05, 8'h04, 8'h00);
    wait_idle();
    check({23'h0, seen_setup, seen_start}, 32'h105, "setup start");
    rd_chk(HR_DATA, 32'h04, RESP_OKAY);
    cmd(32'h0883, 8'h00, 8'h00);
    wait_idle();
    check({16'h0, seen_stop, seen_start}, 32'h8300, "channel stop");
    cmd(32'h1083, 8'h02, 8'h80);
    wait_idle();
    check({24'h0, seen_xfer}, 32'h83, "transfer mask");
    rd_chk(HR_DATA, 32'h82, RESP_OKAY);
    cmd(32'h0A03, 8'h00, 8'h00);
    wait_idle();
    check({16'h0, seen_stop, seen_start}, 32'h0, "unknown type");
    cmd(32'h4000, 8'h00, 8'h00);
    wait_idle();
    check({30'h0, seen_proc, prog_open}, 32'h3, "processor reset");
    axi_wr(HR_DATA, 32'h5A);
    cmd(32'hA005, 8'h00, 8'h00);
    wait_idle();
    check({31'h0, prog_open}, 32'h0, "store closed");
    axi_wr(HR_DATA, 32'h00);
    cmd(32'h2005, 8'h00, 8'h00);
    wait_idle();
    rd_chk(HR_DATA, 32'h5A, RESP_OKAY);
    cmd(32'h8000_0901, 8'h00, 8'h00);
    rd_chk(HR_CMD, 32'h0, RESP_OKAY);
    check({24'h0, seen_start}, 32'h0, "ignored write");
    cmd(32'h0901, 8'h00, 8'h01);
    rd_chk(HR_CMD, 32'h0901, RESP_OKAY);
    axi_wr(HR_CMD, 32'h0902);
    rd_chk(HR_STAT, 32'h3, RESP_OKAY);
    rd_chk(HR_CMD, 32'h0901, RESP_OKAY);
    cmd(32'h0800, 8'h00, 8'h00);
    wait_idle();
    check({23'h0, seen_rst, seen_stop}, 32'h1FF, "stop-all");
    axi_wr(HR_STAT, 32'h2);
    check({30'h0, r}, {30'h0, RESP_OKAY}, "status write response");
    rd_chk(HR_STAT, 32'h0, RESP_OKAY);
    summarize();
  end
endmodule

`default_nettype wire
